// ### src/dli_bank_if.sv
// Carrier between the register front end and one sticky flag bank.
// Assumes one clock domain shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface dli_bank_if #(
	parameter int unsigned W = 2
);
	logic [W-1:0] event_set;
	logic         read_clear;
	logic         w1c_en;
	logic         mask_we;
	logic [W-1:0] wdata;
	logic [W-1:0] flag;
	logic [W-1:0] mask;
	logic         pending;

	modport bank (
		input  event_set,
		input  read_clear,
		input  w1c_en,
		input  mask_we,
		input  wdata,
		output flag,
		output mask,
		output pending
	);
	modport ctrl (
		output event_set,
		output read_clear,
		output w1c_en,
		output mask_we,
		output wdata,
		input  flag,
		input  mask,
		input  pending
	);
endinterface
`default_nettype wire

// ### src/dli_flag_bank.sv
// One group of sticky interrupt flags with their masks.
// Assumes single-cycle clear and write strobes from the register front end.
`timescale 1ns/100ps
`default_nettype none
module dli_flag_bank
	import dli_pkg::*;
#(
	parameter int unsigned    W         = 2,
	parameter logic [W-1:0]   STAT_RST  = '0,
	parameter logic [W-1:0]   MASK_RST  = '1
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	dli_bank_if.bank  bus
);
	logic [W-1:0] flag_q;
	logic [W-1:0] flag_d;
	logic [W-1:0] mask_q;
	logic [W-1:0] clr_vec;

	// Read clears every bit; write-one clears only the bits written
	assign clr_vec = bus.read_clear ? {W{1'b1}} : (bus.w1c_en ? bus.wdata : '0);
	// Set beats clear so an event in the clearing cycle survives
	assign flag_d  = (flag_q & ~clr_vec) | bus.event_set;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flag_q <= STAT_RST;
			mask_q <= MASK_RST;
		end else begin
			flag_q <= flag_d;
			if (bus.mask_we) begin
				mask_q <= bus.wdata;
			end
		end
	end

	assign bus.flag    = flag_q;
	assign bus.mask    = mask_q;
	// Masked flags still record, they just do not pull the pin
	assign bus.pending = |(flag_q & ~mask_q);
endmodule
`default_nettype wire

// ### src/dli_irq_regs.sv
// Interrupt status, mask and sense registers for buck scaling-done and linear faults.
// Assumes a byte register port from the serial control interface, single-cycle strobes,
// and live regulator indications arriving asynchronously from the analog side.
//
// Contract
// - Buck A flag sets when scaling finishes
// - Buck B flag bit 1 sets on scaling finish
// - Scaling-done status resets zero, upper bits unused
// - Status bit stays one until cleared
// - Read or write-one clears status bit
// - Unmasked set flag pulls interrupt pin low
// - Masked flag records but leaves pin alone
// - Scaling mask bits 0,1 reset to one
// - Sense register shows live scaling busy
// - Linear fault flags latch at bits 0-2
// - Linear fault masks read-write, reset one
// - Linear sense shows live current-limit faults
`timescale 1ns/100ps
`default_nettype none
module dli_irq_regs
	import dli_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire logic              buck_a_scaling_busy,
	input  wire logic              buck_b_scaling_busy,
	input  wire logic              linreg_a_fault_live,
	input  wire logic              linreg_b_fault_live,
	input  wire logic              linreg_c_fault_live,
	input  wire logic [DLI_AW-1:0] reg_addr,
	input  wire logic              reg_rd,
	input  wire logic              reg_wr,
	input  wire logic [DLI_DW-1:0] reg_wdata,
	output logic      [DLI_DW-1:0] reg_rdata,
	input  wire logic              irq_out_n_in,
	output logic                   irq_out_n,
	output logic                   irq_out_n_oe_n
);
	localparam int unsigned NIN = DLI_BUCK_W + DLI_LINREG_W;

	function automatic logic hit(input logic [DLI_AW-1:0] a, input logic [DLI_AW-1:0] r);
		hit = (a == r);
	endfunction

	// Raw pins: buck busy in the low bits, linear faults above
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] s1_q;
	logic [NIN-1:0] s2_q;
	logic [NIN-1:0] s3_q;
	logic [NIN-1:0] live_q;
	logic [NIN-1:0] live_prev_q;
	logic [NIN-1:0] live_d;

	assign raw_in = {linreg_c_fault_live, linreg_b_fault_live, linreg_a_fault_live,
		buck_b_scaling_busy, buck_a_scaling_busy};

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			// Filtered level moves only once stages two and three agree
			assign live_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : live_q[gi];
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_q        <= '0;
			s2_q        <= '0;
			s3_q        <= '0;
			live_q      <= '0;
			live_prev_q <= '0;
		end else begin
			s1_q        <= raw_in;
			s2_q        <= s1_q;
			s3_q        <= s2_q;
			live_q      <= live_d;
			live_prev_q <= live_q;
		end
	end

	logic [DLI_BUCK_W-1:0]   buck_live;
	logic [DLI_LINREG_W-1:0] linreg_live;
	logic [DLI_BUCK_W-1:0]   buck_done_evt;
	logic [DLI_LINREG_W-1:0] linreg_fault_evt;

	assign buck_live   = live_q[DLI_BUCK_W-1:0];
	assign linreg_live = live_q[NIN-1:DLI_BUCK_W];
	// End of any voltage change, whatever started it, is busy falling
	assign buck_done_evt = live_prev_q[DLI_BUCK_W-1:0] & ~buck_live;
	// A new current-limit fault is the rising edge of its live level
	assign linreg_fault_evt = live_q[NIN-1:DLI_BUCK_W] & ~live_prev_q[NIN-1:DLI_BUCK_W];

	// Register decode
	wire hit_bstat  = hit(reg_addr, DLI_ADDR_BUCK_DONE_STAT);
	wire hit_bmask  = hit(reg_addr, DLI_ADDR_BUCK_DONE_MASK);
	wire hit_bsense = hit(reg_addr, DLI_ADDR_BUCK_SENSE);
	wire hit_lstat  = hit(reg_addr, DLI_ADDR_LINREG_STAT);
	wire hit_lmask  = hit(reg_addr, DLI_ADDR_LINREG_MASK);
	wire hit_lsense = hit(reg_addr, DLI_ADDR_LINREG_SENSE);

	dli_bank_if #(.W(DLI_BUCK_W))   buck_if ();
	dli_bank_if #(.W(DLI_LINREG_W)) linreg_if ();

	assign buck_if.event_set  = buck_done_evt;
	assign buck_if.read_clear = reg_rd & hit_bstat;
	assign buck_if.w1c_en     = reg_wr & hit_bstat;
	assign buck_if.mask_we    = reg_wr & hit_bmask;
	assign buck_if.wdata      = reg_wdata[DLI_BUCK_W-1:0];

	assign linreg_if.event_set  = linreg_fault_evt;
	assign linreg_if.read_clear = reg_rd & hit_lstat;
	assign linreg_if.w1c_en     = reg_wr & hit_lstat;
	assign linreg_if.mask_we    = reg_wr & hit_lmask;
	assign linreg_if.wdata      = reg_wdata[DLI_LINREG_W-1:0];

	dli_flag_bank #(
		.W        (DLI_BUCK_W),
		.STAT_RST (DLI_BUCK_STAT_RST),
		.MASK_RST (DLI_BUCK_MASK_RST)
	) u_buck_bank (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.bus     (buck_if)
	);

	dli_flag_bank #(
		.W        (DLI_LINREG_W),
		.STAT_RST (DLI_LINREG_STAT_RST),
		.MASK_RST (DLI_LINREG_MASK_RST)
	) u_linreg_bank (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.bus     (linreg_if)
	);

	// Read mux; unused bits and unmapped addresses read zero
	localparam int unsigned BPAD = DLI_DW - DLI_BUCK_W;
	localparam int unsigned LPAD = DLI_DW - DLI_LINREG_W;
	wire [DLI_DW-1:0] rd_bstat  = {{BPAD{1'b0}}, buck_if.flag};
	wire [DLI_DW-1:0] rd_bmask  = {{BPAD{1'b0}}, buck_if.mask};
	wire [DLI_DW-1:0] rd_bsense = {{BPAD{1'b0}}, buck_live};
	wire [DLI_DW-1:0] rd_lstat  = {{LPAD{1'b0}}, linreg_if.flag};
	wire [DLI_DW-1:0] rd_lmask  = {{LPAD{1'b0}}, linreg_if.mask};
	wire [DLI_DW-1:0] rd_lsense = {{LPAD{1'b0}}, linreg_live};
	wire [DLI_DW-1:0] rdata_d =
		hit_bstat  ? rd_bstat  :
		hit_bmask  ? rd_bmask  :
		hit_bsense ? rd_bsense :
		hit_lstat  ? rd_lstat  :
		hit_lmask  ? rd_lmask  :
		hit_lsense ? rd_lsense : DLI_RDATA_RST;

	logic [DLI_DW-1:0] rdata_q;
	logic              irq_oe_n_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdata_q    <= DLI_RDATA_RST;
			irq_oe_n_q <= 1'b1;
		end else begin
			// Data is captured before the same edge clears the flags
			if (reg_rd) begin
				rdata_q <= rdata_d;
			end
			irq_oe_n_q <= ~(buck_if.pending | linreg_if.pending);
		end
	end

	assign reg_rdata      = rdata_q;
	// Open-drain pin: only ever drives low, released pin is pulled up outside
	assign irq_out_n      = 1'b0;
	assign irq_out_n_oe_n = irq_oe_n_q;
endmodule
`default_nettype wire

// ### src/dli_pkg.sv
// Register map and reset values of the scaling-done and linear-fault interrupt block.
// Assumes byte-wide registers reached by an 8-bit register address.
package dli_pkg;
	localparam int unsigned DLI_AW = 8;
	localparam int unsigned DLI_DW = 8;

	localparam logic [7:0] DLI_ADDR_BUCK_DONE_STAT  = 8'h0E;
	localparam logic [7:0] DLI_ADDR_BUCK_DONE_MASK  = 8'h0F;
	localparam logic [7:0] DLI_ADDR_BUCK_SENSE      = 8'h10;
	localparam logic [7:0] DLI_ADDR_LINREG_STAT     = 8'h18;
	localparam logic [7:0] DLI_ADDR_LINREG_MASK     = 8'h19;
	localparam logic [7:0] DLI_ADDR_LINREG_SENSE    = 8'h1A;

	// Field widths; fields sit from bit 0 upward
	localparam int unsigned DLI_BUCK_W   = 2;
	localparam int unsigned DLI_LINREG_W = 3;
	localparam int unsigned DLI_BUCK_A_POS   = 0;
	localparam int unsigned DLI_BUCK_B_POS   = 1;
	localparam int unsigned DLI_LINREG_A_POS = 0;
	localparam int unsigned DLI_LINREG_B_POS = 1;
	localparam int unsigned DLI_LINREG_C_POS = 2;

	localparam logic [1:0] DLI_BUCK_STAT_RST   = 2'h0;
	localparam logic [1:0] DLI_BUCK_MASK_RST   = 2'h3;
	localparam logic [2:0] DLI_LINREG_STAT_RST = 3'h0;
	localparam logic [2:0] DLI_LINREG_MASK_RST = 3'h7;
	localparam logic [7:0] DLI_RDATA_RST       = 8'h00;

	// Pin inputs pass this many synchroniser flip-flops before the filter flop
	localparam int unsigned DLI_SYNC_STAGES = 3;
endpackage

// ### verification/dli_host_pin.sv
// Host end of the interrupt line: open-drain wire with a pull-up.
// Assumes the block pulls low only while its enable is low.
`timescale 1ns/100ps
`default_nettype none
module dli_host_pin (
	input  wire logic oe_n,
	input  wire logic data,
	output logic      pin
);
	// Released line floats up to the pull-up level
	assign pin = oe_n ? 1'b1 : data;
endmodule
`default_nettype wire

// ### verification/dli_irq_regs_sva.sv
// Concurrent checks on the interrupt register block ports.
// Assumes one clock, synchronous reset and the three-flop input synchroniser.
`timescale 1ns/100ps
`default_nettype none
module dli_irq_regs_sva
	import dli_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       sys_rst,
	input wire logic       buck_a_scaling_busy,
	input wire logic       buck_b_scaling_busy,
	input wire logic       linreg_a_fault_live,
	input wire logic       linreg_b_fault_live,
	input wire logic       linreg_c_fault_live,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       irq_out_n,
	input wire logic       irq_out_n_oe_n
);
	logic [4:0] src_q;
	logic [2:0] quiet_q;
	wire  logic [2:0] quiet_d;
	wire  logic [4:0] src;
	wire  logic       quiet;
	wire  logic       idle;
	assign src = {linreg_c_fault_live, linreg_b_fault_live, linreg_a_fault_live,
		buck_b_scaling_busy, buck_a_scaling_busy};
	// Seven calm edges flush synchroniser and edge detect
	assign quiet   = (quiet_q == 3'h7) && (src == src_q);
	assign quiet_d = (src != src_q) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
	assign idle    = !reg_rd && !reg_wr;
	always_ff @(posedge clk_sys) begin
		src_q   <= src;
		quiet_q <= sys_rst ? 3'h0 : quiet_d;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	pin_data_a: assert property (irq_out_n == 1'b0) else $error("pin data high");
	reset_state_a: assert property ($past(sys_rst) |-> irq_out_n_oe_n && reg_rdata == 8'h00)
		else $error("bad reset outputs");
	buck_upper_a: assert property (reg_rd && reg_addr inside {8'h0E, 8'h0F, 8'h10}
		|=> reg_rdata[7:2] == 6'h00) else $error("buck upper bits set");
	mask_rw_a: assert property (reg_wr && reg_addr == 8'h0F ##2 reg_rd && reg_addr == 8'h0F
		|=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3)) else $error("mask readback");
	read_clear_a: assert property (quiet && reg_rd && reg_addr == 8'h0E
		##2 reg_rd && reg_addr == 8'h0E |=> reg_rdata == 8'h00) else $error("flag not cleared");
	sense_live_a: assert property (quiet && reg_rd && reg_addr == 8'h10
		|=> reg_rdata == {6'h00, $past(src[1:0])}) else $error("buck sense");
	fault_live_a: assert property (quiet && reg_rd && reg_addr == 8'h1A
		|=> reg_rdata == {5'h00, $past(src[4:2])}) else $error("fault sense");
	release_cause_a: assert property ($rose(irq_out_n_oe_n) |-> $past(!idle, 2))
		else $error("pin released without access");
	hold_quiet_a: assert property (quiet && idle ##1 idle |=> $stable(irq_out_n_oe_n))
		else $error("pin moved while calm");
endmodule
bind dli_irq_regs dli_irq_regs_sva u_sva (.clk_sys, .sys_rst, .buck_a_scaling_busy,
	.buck_b_scaling_busy, .linreg_a_fault_live, .linreg_b_fault_live, .linreg_c_fault_live,
	.reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .irq_out_n, .irq_out_n_oe_n);
`default_nettype wire

// ### verification/tb_top.sv
// Register-level bench for the interrupt block with event stimulus.
// Assumes the bound checker and a host pull-up on the pin.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import dli_pkg::*;
;
	logic       clk_sys   = 1'b0;
	logic       sys_rst   = 1'b1;
	logic [4:0] src       = 5'h00;
	logic [7:0] reg_addr  = 8'h00;
	logic       reg_rd    = 1'b0;
	logic       reg_wr    = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	wire  logic [7:0] reg_rdata;
	wire  logic       irq_out_n;
	wire  logic       irq_out_n_oe_n;
	wire  logic       pin;
	int         bad_count = 0;
	int         tests_run = 0;
	dli_irq_regs dut (.clk_sys, .sys_rst, .buck_a_scaling_busy(src[0]),
		.buck_b_scaling_busy(src[1]), .linreg_a_fault_live(src[2]), .linreg_b_fault_live(src[3]),
		.linreg_c_fault_live(src[4]), .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata,
		.irq_out_n_in(pin), .irq_out_n, .irq_out_n_oe_n);
	dli_host_pin host (.oe_n(irq_out_n_oe_n), .data(irq_out_n), .pin(pin));
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd   <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	// Fixed wait covers sync, edge detect and pin register
	task automatic ev(input logic [4:0] v);
		@(posedge clk_sys);
		src <= v;
		repeat (8) @(posedge clk_sys);
	endtask
	task automatic pin_is(input logic e);
		repeat (2) @(posedge clk_sys);
		#1;
		chk({7'h00, pin}, {7'h00, e});
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		bad_count++;
		finish_test;
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(DLI_ADDR_BUCK_DONE_STAT, 8'h00);
		rd(DLI_ADDR_BUCK_DONE_MASK, 8'h03);
		rd(DLI_ADDR_LINREG_STAT, 8'h00);
		rd(DLI_ADDR_LINREG_MASK, 8'h07);
		rd(DLI_ADDR_BUCK_SENSE, 8'h00);
		rd(DLI_ADDR_LINREG_SENSE, 8'h00);
		pin_is(1'b1);
		$display("reset values done");
		ev(5'h01);
		rd(DLI_ADDR_BUCK_SENSE, 8'h01);
		ev(5'h00);
		pin_is(1'b1);
		rd(DLI_ADDR_BUCK_DONE_STAT, 8'h01);
		rd(DLI_ADDR_BUCK_DONE_STAT, 8'h00);
		$display("masked scaling done");
		wr(DLI_ADDR_BUCK_DONE_MASK, 8'hFC);
		rd(DLI_ADDR_BUCK_DONE_MASK, 8'h00);
		ev(5'h02);
		ev(5'h00);
		pin_is(1'b0);
		wr(DLI_ADDR_BUCK_DONE_STAT, 8'h01);
		pin_is(1'b0);
		rd(DLI_ADDR_BUCK_DONE_STAT, 8'h02);
		pin_is(1'b1);
		ev(5'h02);
		ev(5'h00);
		wr(DLI_ADDR_BUCK_DONE_STAT, 8'h02);
		pin_is(1'b1);
		rd(DLI_ADDR_BUCK_DONE_STAT, 8'h00);
		ev(5'h01);
		// Busy falls so that the done event meets the clearing read
		@(posedge clk_sys);
		src <= 5'h00;
		repeat (3) @(posedge clk_sys);
		rd(DLI_ADDR_BUCK_DONE_STAT, 8'h00);
		rd(DLI_ADDR_BUCK_DONE_STAT, 8'h01);
		$display("unmasked scaling done");
		wr(DLI_ADDR_LINREG_MASK, 8'h06);
		rd(DLI_ADDR_LINREG_MASK, 8'h06);
		ev(5'h1C);
		rd(DLI_ADDR_LINREG_SENSE, 8'h07);
		pin_is(1'b0);
		rd(DLI_ADDR_LINREG_STAT, 8'h07);
		pin_is(1'b1);
		rd(DLI_ADDR_LINREG_STAT, 8'h00);
		ev(5'h00);
		ev(5'h1C);
		pin_is(1'b0);
		wr(DLI_ADDR_LINREG_STAT, 8'h01);
		pin_is(1'b1);
		rd(DLI_ADDR_LINREG_STAT, 8'h06);
		ev(5'h00);
		$display("linear faults done");
		finish_test;
	end
endmodule
`default_nettype wire
